/* File: common/switch_global_consts.svh */
// named constants for the global identity and control register bank
// assumes inclusion by bare name from design files
`ifndef SWITCH_GLOBAL_CONSTS_SVH
`define SWITCH_GLOBAL_CONSTS_SVH

// register byte offsets
`define OFS_FAMILY        8'h00
`define OFS_CHIP_RUN      8'h01
`define OFS_GC0           8'h02
`define OFS_GC1           8'h03

// chip code and run control fields
`define RUN_BIT           0
`define RUN_RST           1'b1

// global control zero fields
`define GC0_ALT_BACKOFF   7
`define GC0_SOFT_RST      6
`define GC0_FLUSH_DYN     5
`define GC0_FLUSH_STA     4
`define GC0_CONF_DROP     1
`define GC0_LINK_AGE      0
`define GC0_WR_MASK       8'hC3
`define GC0_FIXED_ONES    8'h0C
`define GC0_RST           8'h00

// global control one fields
`define GC1_JUMBO         6
`define GC1_TXFC_DIS      5
`define GC1_RXFC_DIS      4
`define GC1_LEN_CHK       3
`define GC1_AGE_EN        2
`define GC1_FAST_AGE      1
`define GC1_AGGR_BACKOFF  0
`define GC1_WR_MASK       8'h7F
`define GC1_RST           8'h04

// frame classification
`define PAUSE_TYPE        16'h8808
`define PAUSE_DA          48'h0180C2000001
`define LEN_TYPE_LIMIT    16'h05DC

// timing
`define CLK_HZ            64'd125000000
`define FAST_AGE_US       64'd800
`define NORM_AGE_S        64'd300
`define FAST_AGE_CYC      ((`FAST_AGE_US * `CLK_HZ) / 64'd1000000)
`define NORM_AGE_CYC      (`NORM_AGE_S * `CLK_HZ)

`endif

/* File: common/switch_global_pkg.sv */
// types shared by the global control register bank and its helpers
// assumes nothing beyond a single core clock
package switch_global_pkg;

  typedef enum logic [1:0] {FL_IDLE, FL_READ, FL_CHECK} flush_state_t;

  typedef struct packed {
    logic       run;
    logic [7:0] gc0;
    logic [7:0] gc1;
    logic       strap_load;
    logic [1:0] strap_s;
    logic [3:0] link_s1;
    logic [3:0] link_s2;
    logic [3:0] link_prev;
    logic       start_dyn;
    logic       start_sta;
    logic       age_all;
    logic       fast_once;
    logic [3:0] tx_pause;
    logic [3:0] rx_pause;
    logic       drop;
    logic       verdict;
    logic [7:0] rdata;
    logic       spi_ack;
    logic       miim_ack;
  } regs_t;

  function automatic logic one_hot4(input logic [3:0] v);
    return (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction : one_hot4

endpackage : switch_global_pkg

/* File: verilog/aging_timer.sv */
// address aging pass generator: normal or fast period, plus single fast passes
// assumes control inputs come from logic on the same clock
`timescale 1ns/1ps
`include "switch_global_consts.svh"

module aging_timer #(
  parameter longint unsigned NORM_CYC = `NORM_AGE_CYC,
  parameter longint unsigned FAST_CYC = `FAST_AGE_CYC
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic age_en,
  input  wire logic fast_en,
  input  wire logic fast_once,
  output logic      age_tick
);

  initial
  begin
    if (FAST_CYC < 1 || NORM_CYC < FAST_CYC)
      $error("aging_timer: periods out of range");
  end

  typedef struct packed {
    logic [63:0] cnt;
    logic        once;
    logic        tick;
  } age_t;

  age_t        q;
  age_t        d;
  logic [63:0] limit;

  always_comb
  begin
    d     = q;
    d.tick = 1'b0;
    limit = (fast_en || q.once) ? FAST_CYC - 64'd1 : NORM_CYC - 64'd1;
    if (!age_en)
      d.cnt = 64'h0;
    else if (q.cnt >= limit)
    begin
      d.cnt  = 64'h0;
      d.tick = 1'b1;
      d.once = 1'b0;
    end
    else
      d.cnt = q.cnt + 64'h1;
    // a new unplug event during the closing pass still earns its own pass
    if (fast_once)
      d.once = 1'b1;
    if (!rst_n)
      d = '0;
  end

  always_ff @(posedge clock)
  begin
    q <= d;
  end

  assign age_tick = q.tick;

endmodule : aging_timer

/* File: verilog/flush_sequencer.sv */
// walks an address table and deletes entries owned by learning-disabled ports
// assumes table read data is valid one cycle after tbl_rd
`timescale 1ns/1ps

module flush_sequencer #(
  parameter int DEPTH        = 1024,
  parameter bit STATIC_MATCH = 1'b0
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic                     start,
  input  wire logic [3:0]               learn_disable,
  output logic                          tbl_rd,
  output logic [$clog2(DEPTH)-1:0]      tbl_idx,
  input  wire logic                     tbl_valid,
  input  wire logic                     tbl_unicast,
  input  wire logic [3:0]               tbl_ports,
  output logic                          tbl_del,
  output logic                          busy
);

  localparam int IW = $clog2(DEPTH);
  localparam logic [IW-1:0] LAST = IW'(DEPTH - 1);

  initial
  begin
    if (DEPTH < 2)
      $error("flush_sequencer: DEPTH must be at least 2");
  end

  typedef struct packed {
    switch_global_pkg::flush_state_t st;
    logic [IW-1:0]                   idx;
  } fl_t;

  fl_t  q;
  fl_t  d;
  logic owned;
  logic hit;

  always_comb
  begin
    owned = (tbl_ports & learn_disable) != 4'h0;
    if (STATIC_MATCH)
      hit = tbl_valid && tbl_unicast && switch_global_pkg::one_hot4(tbl_ports) && owned;
    else
      hit = tbl_valid && owned;
    d = q;
    unique case (q.st)
      switch_global_pkg::FL_IDLE:
      begin
        d.idx = '0;
        if (start)
          d.st = switch_global_pkg::FL_READ;
      end
      switch_global_pkg::FL_READ:
        d.st = switch_global_pkg::FL_CHECK;
      switch_global_pkg::FL_CHECK:
      begin
        if (q.idx == LAST)
          d.st = switch_global_pkg::FL_IDLE;
        else
        begin
          d.idx = q.idx + IW'(1);
          d.st  = switch_global_pkg::FL_READ;
        end
      end
    endcase
    if (!rst_n)
      d = '{st: switch_global_pkg::FL_IDLE, idx: '0};
  end

  always_ff @(posedge clock)
  begin
    q <= d;
  end

  assign tbl_rd  = (q.st == switch_global_pkg::FL_READ);
  assign tbl_idx = q.idx;
  assign tbl_del = (q.st == switch_global_pkg::FL_CHECK) && hit;
  assign busy    = (q.st != switch_global_pkg::FL_IDLE);

endmodule : flush_sequencer

/* File: verilog/switch_global_control_regs.sv */
// global identity and control registers of the four-port switch core
// assumes spi and miim front ends on the core clock hold a request until ack;
// link pins and the flow-control strap are asynchronous
`timescale 1ns/1ps
`include "switch_global_consts.svh"

// Summary of operation
// - run bit starts or halts switching
// - bit selects alternative conformance back-off
// - soft reset clears machines, keeps configuration
// - write one flushes learned table, self-clears
// - learned flush removes learning-disabled ports only
// - static flush deletes single-port unicast matches
// - conformance mode picks pause drop criterion
// - unplug triggers one fast aging pass
// - unplug ages out all learned addresses
// - bit permits two kilobyte frames
// - transmit pause follows negotiation unless disabled
// - receive pause follows negotiation unless disabled
// - one strap sets both pause disables
// - length field checked, mismatches dropped
// - aging enable bit, reset set
// - fast aging period selectable
// - aggressive half-duplex back-off enable
// - reachable from both spi and miim
module switch_global_control_regs #(
  parameter logic [7:0]      FAMILY_CODE = 8'h5A,  // arbitrary identity value
  parameter logic [3:0]      CHIP_CODE   = 4'hA,   // arbitrary identity value
  parameter logic [2:0]      REV_CODE    = 3'h1,   // arbitrary identity value
  parameter int              DYN_DEPTH   = 1024,
  parameter int              STA_DEPTH   = 32,
  parameter longint unsigned NORM_CYC    = `NORM_AGE_CYC,
  parameter longint unsigned FAST_CYC    = `FAST_AGE_CYC
) (
  input  wire logic                         clock,
  input  wire logic                         rst_n,
  input  wire logic                         spi_req,
  input  wire logic                         spi_wr,
  input  wire logic [7:0]                   spi_addr,
  input  wire logic [7:0]                   spi_wdata,
  output logic [7:0]                        spi_rdata,
  output logic                              spi_ack,
  input  wire logic                         miim_req,
  input  wire logic                         miim_wr,
  input  wire logic [7:0]                   miim_addr,
  input  wire logic [7:0]                   miim_wdata,
  output logic [7:0]                        miim_rdata,
  output logic                              miim_ack,
  input  wire logic                         fc_disable_strap,
  input  wire logic [3:0]                   link_up,
  input  wire logic [3:0]                   an_tx_pause,
  input  wire logic [3:0]                   an_rx_pause,
  input  wire logic [3:0]                   learn_disable,
  input  wire logic                         frame_valid,
  input  wire logic [47:0]                  frame_dst,
  input  wire logic [15:0]                  frame_type_len,
  input  wire logic [15:0]                  frame_payload_len,
  input  wire logic                         frame_is_pause,
  output logic                              frame_verdict,
  output logic                              frame_drop,
  output logic                              dyn_rd,
  output logic [$clog2(DYN_DEPTH)-1:0]      dyn_idx,
  input  wire logic                         dyn_valid,
  input  wire logic [3:0]                   dyn_port,
  output logic                              dyn_del,
  output logic                              sta_rd,
  output logic [$clog2(STA_DEPTH)-1:0]      sta_idx,
  input  wire logic                         sta_valid,
  input  wire logic                         sta_unicast,
  input  wire logic [3:0]                   sta_ports,
  output logic                              sta_del,
  output logic                              switch_run,
  output logic                              datapath_rst_n,
  output logic                              alt_backoff_en,
  output logic                              aggressive_backoff_en,
  output logic                              jumbo_en,
  output logic                              length_check_en,
  output logic [3:0]                        tx_pause_en,
  output logic [3:0]                        rx_pause_en,
  output logic                              age_tick,
  output logic                              age_out_all
);

  initial
  begin
    if (DYN_DEPTH < 2 || STA_DEPTH < 2)
      $error("switch_global_control_regs: table depths must be at least 2");
  end

  switch_global_pkg::regs_t q;
  switch_global_pkg::regs_t d;

  logic       spi_sel;
  logic       miim_sel;
  logic       acc;
  logic       acc_wr;
  logic [7:0] acc_addr;
  logic [7:0] acc_wdata;
  logic [7:0] rd_val;
  logic       dyn_busy;
  logic       sta_busy;
  logic       core_rst_n;
  logic       unplug;
  logic       fc_dis_now;

  assign core_rst_n = rst_n && !q.gc0[`GC0_SOFT_RST];

  // spi wins a tie, miim waits
  assign spi_sel   = spi_req && !q.spi_ack;
  assign miim_sel  = miim_req && !q.miim_ack && !spi_sel;
  assign acc       = spi_sel || miim_sel;
  assign acc_wr    = spi_sel ? spi_wr : miim_wr;
  assign acc_addr  = spi_sel ? spi_addr : miim_addr;
  assign acc_wdata = spi_sel ? spi_wdata : miim_wdata;

  // any port link to no link
  assign unplug = (q.link_prev & ~q.link_s2) != 4'h0;

  always_comb
  begin
    rd_val = 8'h00;
    unique case (acc_addr)
      `OFS_FAMILY:
        rd_val = FAMILY_CODE;
      `OFS_CHIP_RUN:
        rd_val = {CHIP_CODE, REV_CODE, q.run};
      // flush bits read busy until done
      `OFS_GC0:
      begin
        rd_val = q.gc0 | `GC0_FIXED_ONES;
        rd_val[`GC0_FLUSH_DYN] = dyn_busy || q.start_dyn;
        rd_val[`GC0_FLUSH_STA] = sta_busy || q.start_sta;
      end
      `OFS_GC1:
        rd_val = q.gc1 & `GC1_WR_MASK;
      default:
        rd_val = 8'h00;
    endcase
  end

  always_comb
  begin
    d           = q;
    d.start_dyn = 1'b0;
    d.start_sta = 1'b0;
    d.age_all   = 1'b0;
    d.fast_once = 1'b0;
    d.verdict   = 1'b0;
    d.spi_ack   = spi_sel;
    d.miim_ack  = miim_sel;
    fc_dis_now  = 1'b0;

    d.link_s1   = link_up;
    d.link_s2   = q.link_s1;
    d.link_prev = q.link_s2;
    d.strap_s   = {q.strap_s[0], fc_disable_strap};

    if (q.strap_load)
    begin
      fc_dis_now = q.strap_s[1];
      d.gc1[`GC1_TXFC_DIS] = fc_dis_now;
      d.gc1[`GC1_RXFC_DIS] = fc_dis_now;
      d.strap_load = 1'b0;
    end

    if (acc)
      d.rdata = rd_val;

    if (acc && acc_wr)
    begin
      unique case (acc_addr)
        `OFS_CHIP_RUN:
          d.run = acc_wdata[`RUN_BIT];
        `OFS_GC0:
        begin
          d.gc0 = acc_wdata & `GC0_WR_MASK;
          d.start_dyn = acc_wdata[`GC0_FLUSH_DYN] && !dyn_busy;
          d.start_sta = acc_wdata[`GC0_FLUSH_STA] && !sta_busy;
        end
        `OFS_GC1:
          d.gc1 = acc_wdata & `GC1_WR_MASK;
        default:
        begin
        end
      endcase
    end

    if (unplug && q.gc0[`GC0_LINK_AGE])
    begin
      d.fast_once = 1'b1;
      d.age_all   = 1'b1;
    end

    d.tx_pause = q.gc1[`GC1_TXFC_DIS] ? 4'h0 : an_tx_pause;
    d.rx_pause = q.gc1[`GC1_RXFC_DIS] ? 4'h0 : an_rx_pause;

    if (frame_valid)
    begin
      d.verdict = 1'b1;
      d.drop    = 1'b0;
      if (q.gc0[`GC0_CONF_DROP])
      begin
        if (frame_type_len == `PAUSE_TYPE || frame_dst == `PAUSE_DA)
          d.drop = 1'b1;
      end
      else if (frame_is_pause)
        d.drop = 1'b1;
      if (q.gc1[`GC1_LEN_CHK] && frame_type_len < `LEN_TYPE_LIMIT &&
          frame_type_len != frame_payload_len)
        d.drop = 1'b1;
    end

    if (q.gc0[`GC0_SOFT_RST])
    begin
      d.verdict   = 1'b0;
      d.drop      = 1'b0;
      d.start_dyn = 1'b0;
      d.start_sta = 1'b0;
      d.fast_once = 1'b0;
      d.age_all   = 1'b0;
    end

    // synchronous reset; the synchroniser keeps sampling so the strap is
    // settled when the load happens at the first edge after release
    if (!rst_n)
    begin
      d            = '0;
      d.run        = `RUN_RST;
      d.gc0        = `GC0_RST;
      d.gc1        = `GC1_RST;
      d.strap_load = 1'b1;
      d.strap_s    = {q.strap_s[0], fc_disable_strap};
      d.link_s1    = link_up;
      d.link_s2    = q.link_s1;
      d.link_prev  = q.link_s2;
    end
  end

  always_ff @(posedge clock)
  begin
    q <= d;
  end

  flush_sequencer #(
    .DEPTH        (DYN_DEPTH),
    .STATIC_MATCH (1'b0)
  ) u_dyn_flush (
    .clock         (clock),
    .rst_n         (core_rst_n),
    .start         (q.start_dyn),
    .learn_disable (learn_disable),
    .tbl_rd        (dyn_rd),
    .tbl_idx       (dyn_idx),
    .tbl_valid     (dyn_valid),
    .tbl_unicast   (1'b1),
    .tbl_ports     (dyn_port),
    .tbl_del       (dyn_del),
    .busy          (dyn_busy)
  );

  flush_sequencer #(
    .DEPTH        (STA_DEPTH),
    .STATIC_MATCH (1'b1)
  ) u_sta_flush (
    .clock         (clock),
    .rst_n         (core_rst_n),
    .start         (q.start_sta),
    .learn_disable (learn_disable),
    .tbl_rd        (sta_rd),
    .tbl_idx       (sta_idx),
    .tbl_valid     (sta_valid),
    .tbl_unicast   (sta_unicast),
    .tbl_ports     (sta_ports),
    .tbl_del       (sta_del),
    .busy          (sta_busy)
  );

  aging_timer #(
    .NORM_CYC (NORM_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_aging (
    .clock     (clock),
    .rst_n     (core_rst_n),
    .age_en    (q.gc1[`GC1_AGE_EN]),
    .fast_en   (q.gc1[`GC1_FAST_AGE]),
    .fast_once (q.fast_once),
    .age_tick  (age_tick)
  );

  assign spi_rdata  = q.rdata;
  assign miim_rdata = q.rdata;
  assign spi_ack    = q.spi_ack;
  assign miim_ack   = q.miim_ack;

  assign switch_run            = q.run;
  assign datapath_rst_n        = !q.gc0[`GC0_SOFT_RST];
  assign alt_backoff_en        = q.gc0[`GC0_ALT_BACKOFF];
  assign aggressive_backoff_en = q.gc1[`GC1_AGGR_BACKOFF];
  assign jumbo_en              = q.gc1[`GC1_JUMBO];
  assign length_check_en       = q.gc1[`GC1_LEN_CHK];
  assign tx_pause_en           = q.tx_pause;
  assign rx_pause_en           = q.rx_pause;
  assign age_out_all           = q.age_all;
  assign frame_verdict         = q.verdict;
  assign frame_drop            = q.drop;

endmodule : switch_global_control_regs

/* File: test/switch_global_control_regs_asserts.sv */
// port checker for the global control register bank
// assumes one core clock and the synchronous active-low reset of the top module
`timescale 1ns/1ps

module switch_global_control_regs_asserts (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        spi_req,
  input wire logic        spi_ack,
  input wire logic [7:0]  spi_rdata,
  input wire logic        miim_req,
  input wire logic        miim_ack,
  input wire logic [7:0]  miim_rdata,
  input wire logic        frame_valid,
  input wire logic [15:0] frame_type_len,
  input wire logic [15:0] frame_payload_len,
  input wire logic        frame_verdict,
  input wire logic        frame_drop,
  input wire logic        length_check_en,
  input wire logic        datapath_rst_n,
  input wire logic [3:0]  an_tx_pause,
  input wire logic [3:0]  tx_pause_en,
  input wire logic        dyn_rd,
  input wire logic        dyn_del,
  input wire logic        sta_rd,
  input wire logic        sta_del,
  input wire logic        age_out_all
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_spi_ack_follows: assert property (spi_req && !spi_ack |=> spi_ack)
    else $error("spi request not acked next cycle");
  a_miim_ack_follows: assert property (miim_req && !miim_ack && !spi_req |=> miim_ack)
    else $error("miim request not acked next cycle");
  a_ack_single_cycle: assert property ($rose(spi_ack) |=> !spi_ack)
    else $error("spi ack longer than one cycle");
  a_rdata_hold: assert property (!spi_ack && !miim_ack |-> $stable(spi_rdata) && spi_rdata == miim_rdata)
    else $error("read data moved without an access");
  a_verdict_timing: assert property (frame_valid && datapath_rst_n |=> frame_verdict)
    else $error("no verdict after frame");
  a_verdict_cause: assert property (frame_verdict |-> $past(frame_valid))
    else $error("verdict without frame");
  a_soft_rst_quiet: assert property (!datapath_rst_n |-> !frame_verdict)
    else $error("verdict during soft reset");
  a_len_drop: assert property (frame_verdict && $past(length_check_en)
    && $past(frame_type_len) < 16'h05DC
    && $past(frame_type_len) != $past(frame_payload_len) |-> frame_drop)
    else $error("length mismatch not dropped");
  a_pause_gate: assert property ((tx_pause_en & ~$past(an_tx_pause)) == 4'h0)
    else $error("transmit pause without negotiation");
  a_dyn_del_cause: assert property (dyn_del |-> $past(dyn_rd))
    else $error("learned delete without read");
  a_sta_del_cause: assert property (sta_del |-> $past(sta_rd))
    else $error("static delete without read");
  a_age_out_pulse: assert property (age_out_all |=> !age_out_all)
    else $error("age out pulse too long");

  c_drop: cover property (frame_verdict && frame_drop);
  c_dyn_del: cover property (dyn_del);
  c_sta_del: cover property (sta_del);
  c_age_out: cover property (age_out_all);
endmodule : switch_global_control_regs_asserts

bind switch_global_control_regs switch_global_control_regs_asserts u_chk (
  .clock, .rst_n, .spi_req, .spi_ack, .spi_rdata, .miim_req, .miim_ack, .miim_rdata,
  .frame_valid, .frame_type_len, .frame_payload_len, .frame_verdict, .frame_drop,
  .length_check_en, .datapath_rst_n, .an_tx_pause, .tx_pause_en, .dyn_rd, .dyn_del,
  .sta_rd, .sta_del, .age_out_all);

/* File: test/switch_global_control_regs_bench.sv */
// self-checking bench for the global control register bank
// assumes shortened aging periods and four-entry tables to keep the run short
`timescale 1ns/1ps

module switch_global_control_regs_bench;
  // identity values are arbitrary
  localparam logic [7:0] FAM = 8'h3C;
  localparam logic [3:0] CHIP = 4'h9;
  localparam logic [2:0] REV = 3'h2;
  localparam logic [7:0] ID1 = {CHIP, REV, 1'b1};
  logic        clock = 1'b0, rst_n = 1'b0, fc_disable_strap = 1'b1, bus_wr = 1'b0;
  logic [1:0]  req = 2'b00;
  logic [7:0]  bus_addr = 8'h00, bus_wdata = 8'h00, spi_rdata, miim_rdata, rd;
  logic        spi_ack, miim_ack, frame_verdict, frame_drop, dyn_rd, dyn_del, sta_rd, sta_del;
  logic        switch_run, datapath_rst_n, alt_backoff_en, aggressive_backoff_en, jumbo_en;
  logic        length_check_en, age_tick, age_out_all, frame_valid = 1'b0;
  logic        frame_is_pause = 1'b0, dyn_valid = 1'b0, sta_valid = 1'b0, sta_unicast = 1'b0;
  logic [3:0]  link_up = 4'hF, an_tx_pause = 4'hC, an_rx_pause = 4'h3, learn_disable = 4'h0;
  logic [3:0]  dyn_port = 4'h0, sta_ports = 4'h0, tx_pause_en, rx_pause_en;
  logic [1:0]  dyn_idx, sta_idx;
  logic [47:0] frame_dst = 48'h0;
  logic [15:0] frame_type_len = 16'h0, frame_payload_len = 16'h0;
  int          error_cnt = 0, check_count = 0, cyc = 0, dels = 0, ticks = 0, outs = 0, idxs = 0;

  switch_global_control_regs #(.FAMILY_CODE(FAM), .CHIP_CODE(CHIP), .REV_CODE(REV),
    .DYN_DEPTH(4), .STA_DEPTH(4), .NORM_CYC(40), .FAST_CYC(8)) dut (
    .clock, .rst_n, .spi_req(req[0]), .spi_wr(bus_wr), .spi_addr(bus_addr),
    .spi_wdata(bus_wdata), .spi_rdata, .spi_ack, .miim_req(req[1]), .miim_wr(bus_wr),
    .miim_addr(bus_addr), .miim_wdata(bus_wdata), .miim_rdata, .miim_ack,
    .fc_disable_strap, .link_up, .an_tx_pause, .an_rx_pause, .learn_disable, .frame_valid,
    .frame_dst, .frame_type_len, .frame_payload_len, .frame_is_pause, .frame_verdict,
    .frame_drop, .dyn_rd, .dyn_idx, .dyn_valid, .dyn_port, .dyn_del, .sta_rd, .sta_idx,
    .sta_valid, .sta_unicast, .sta_ports, .sta_del, .switch_run, .datapath_rst_n,
    .alt_backoff_en, .aggressive_backoff_en, .jumbo_en, .length_check_en, .tx_pause_en,
    .rx_pause_en, .age_tick, .age_out_all);

  always #4 clock = ~clock;

  // counted on the falling edge so comb strobes have settled
  always @(negedge clock)
  begin
    dels += int'(dyn_del | sta_del);
    // deleted indices summed as a check on which entries the walk deletes
    if (dyn_del | sta_del)
      idxs += int'(dyn_del ? dyn_idx : sta_idx);
    ticks += int'(age_tick);
    outs += int'(age_out_all);
  end

  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      $display("FAIL t=%0t run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // request held to the edge that samples ack high, then dropped so it is not taken twice
  task automatic acc(input int m, input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge clock);
    req[m] = 1'b1;
    bus_wr = w;
    bus_addr = a;
    bus_wdata = d;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (((m == 0) ? spi_ack : miim_ack) !== 1'b1 && n < 8);
    rd = (m == 0) ? spi_rdata : miim_rdata;
    chk(8'(n < 8), 8'h01);
    @(negedge clock);
    req[m] = 1'b0;
  endtask : acc

  task automatic rdc(input int m, input logic [7:0] a, input logic [7:0] exp);
    acc(m, 1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rdc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(0, 1'b1, a, d);
  endtask : wr

  task automatic frm(input logic [15:0] t, input logic [47:0] da, input logic [15:0] pl,
                     input logic ps, input logic v, input logic dr);
    @(negedge clock);
    frame_type_len = t;
    frame_dst = da;
    frame_payload_len = pl;
    frame_is_pause = ps;
    frame_valid = 1'b1;
    @(negedge clock);
    frame_valid = 1'b0;
    chk(8'(frame_verdict), 8'(v));
    if (v)
      chk(8'(frame_drop), 8'(dr));
  endtask : frm

  task automatic flush(input logic [7:0] b, input int exp);
    @(posedge clock);
    dels = 0;
    idxs = 0;
    wr(8'h02, b);
    rdc(0, 8'h02, 8'h0C | b);
    repeat (12) @(posedge clock);
    chk(8'(dels), 8'(exp));
    chk(8'(idxs), 8'((exp * (exp - 1)) / 2));
    rdc(1, 8'h02, 8'h0C);
  endtask : flush

  // syncs on a pass, then counts passes over the next len cycles
  task automatic age_win(input int len, input int exp);
    int n;
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (age_tick !== 1'b1 && n < 100);
    @(posedge clock);
    ticks = 0;
    repeat (len) @(posedge clock);
    chk(8'(ticks), 8'(exp));
  endtask : age_win

  initial
  begin
    repeat (4) @(negedge clock);
    rst_n = 1'b1;
    rdc(0, 8'h00, FAM);
    rdc(1, 8'h01, ID1);
    rdc(0, 8'h02, 8'h0C);
    rdc(1, 8'h03, 8'h34);
    chk({2'b00, switch_run, datapath_rst_n, tx_pause_en}, 8'h30);
    $display("test reset values done");
    wr(8'h00, 8'h00);
    rdc(0, 8'h00, FAM);
    wr(8'h01, 8'h00);
    rdc(1, 8'h01, {CHIP, REV, 1'b0});
    chk(8'(switch_run), 8'h00);
    acc(1, 1'b1, 8'h01, 8'hFF);
    rdc(0, 8'h01, ID1);
    wr(8'h10, 8'hFF);
    rdc(1, 8'h10, 8'h00);
    wr(8'h02, 8'h83);
    rdc(0, 8'h02, 8'h8F);
    wr(8'h03, 8'hFF);
    rdc(1, 8'h03, 8'h7F);
    chk({alt_backoff_en, aggressive_backoff_en, jumbo_en, length_check_en, tx_pause_en},
        8'hF0);
    wr(8'h03, 8'h24);
    @(negedge clock);
    chk({tx_pause_en, rx_pause_en}, 8'h03);
    wr(8'h03, 8'h14);
    @(negedge clock);
    chk({tx_pause_en, rx_pause_en}, 8'hC0);
    $display("test register access done");
    frm(16'h8808, 48'h0, 16'h0, 1'b0, 1'b1, 1'b1);
    frm(16'h0800, 48'h0180C2000001, 16'h0, 1'b0, 1'b1, 1'b1);
    frm(16'h0800, 48'h0, 16'h0, 1'b1, 1'b1, 1'b0);
    wr(8'h02, 8'h00);
    frm(16'h0800, 48'h0, 16'h0, 1'b1, 1'b1, 1'b1);
    frm(16'h8808, 48'h0180C2000001, 16'h0, 1'b0, 1'b1, 1'b0);
    wr(8'h03, 8'h0C);
    frm(16'h0040, 48'h0, 16'h0041, 1'b0, 1'b1, 1'b1);
    frm(16'h05DB, 48'h0, 16'h0040, 1'b0, 1'b1, 1'b1);
    frm(16'h05DC, 48'h0, 16'h0040, 1'b0, 1'b1, 1'b0);
    frm(16'h0040, 48'h0, 16'h0040, 1'b0, 1'b1, 1'b0);
    $display("test frame drop done");
    wr(8'h02, 8'h40);
    @(negedge clock);
    chk(8'(datapath_rst_n), 8'h00);
    frm(16'h8808, 48'h0, 16'h0, 1'b1, 1'b0, 1'b0);
    rdc(0, 8'h03, 8'h0C);
    wr(8'h02, 8'h00);
    @(negedge clock);
    chk(8'(datapath_rst_n), 8'h01);
    $display("test soft reset done");
    learn_disable = 4'h2;
    dyn_valid = 1'b1;
    dyn_port = 4'h2;
    sta_valid = 1'b1;
    sta_unicast = 1'b1;
    sta_ports = 4'h2;
    flush(8'h20, 4);
    dyn_port = 4'h4;
    flush(8'h20, 0);
    flush(8'h10, 4);
    learn_disable = 4'h6;
    sta_ports = 4'h6;
    flush(8'h10, 0);
    sta_unicast = 1'b0;
    sta_ports = 4'h2;
    flush(8'h10, 0);
    $display("test table flush done");
    wr(8'h03, 8'h00);
    wr(8'h03, 8'h04);
    age_win(80, 2);
    wr(8'h03, 8'h06);
    age_win(48, 6);
    wr(8'h03, 8'h00);
    age_win(48, 0);
    wr(8'h02, 8'h01);
    wr(8'h03, 8'h04);
    age_win(1, 0);
    outs = 0;
    @(negedge clock);
    link_up = 4'hE;
    repeat (20) @(posedge clock);
    chk(8'(ticks), 8'h01);
    chk(8'(outs), 8'h01);
    wr(8'h02, 8'h00);
    @(posedge clock);
    outs = 0;
    @(negedge clock);
    link_up = 4'hC;
    repeat (10) @(posedge clock);
    chk(8'(outs), 8'h00);
    $display("test aging done");
    tally_and_finish();
  end
endmodule : switch_global_control_regs_bench
